// >>> hts_emitter_model.sv
// Emitter and receive path model: one amplitude per sub-frame.
// Assumes amplitude scales with the drive code by a bench-set gain.
`timescale 1ns/1ps
module hts_emitter_model (
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   input  wire logic        sub_start_i,
   input  wire logic [2:0]  tx_en_i,
   input  wire logic [4:0]  code_i,
   input  wire logic [10:0] gain_i,
   output logic             amp_valid_o,
   output logic [15:0]      amp_o
);
   logic [2:0]  dly_q;
   logic [15:0] amp_full;
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i) dly_q <= 3'h0;
      else dly_q <= {dly_q[1:0], sub_start_i};
   end
   // Result only with an emitter lit; garbage otherwise
   assign amp_valid_o = dly_q[2] && (tx_en_i != 3'h0);
   assign amp_full    = 16'(gain_i) * 16'(code_i);
   assign amp_o       = amp_valid_o ? amp_full : ~amp_full;
endmodule : hts_emitter_model

// >>> hts_pkg.sv
// Constants and types for the illumination current and emitter channel sequencer.
// Assumes a 200 MHz system clock, 24-bit wide code and control registers and 16-bit threshold registers.
package hts_pkg;

   // Register offsets
   localparam logic [7:0]  ADDR_TX_CODES   = 8'h29;
   localparam logic [7:0]  ADDR_TX_CTRL    = 8'h2A;
   localparam logic [7:0]  ADDR_SAT_THR    = 8'h2B;
   localparam logic [7:0]  ADDR_ACC_THR    = 8'h2C;

   // Reset values
   localparam logic [23:0] TX_CODES_RST    = 24'h000000;
   localparam logic [23:0] TX_CTRL_RST     = 24'h000000;
   localparam logic [15:0] SAT_THR_RST     = 16'h0000;
   localparam logic [15:0] ACC_THR_RST     = 16'h0000;

   // Field positions in the code register
   localparam int TX0_LOW_LSB   = 0;
   localparam int TX0_HIGH_LSB  = 5;
   localparam int TX1_LOW_LSB   = 10;
   localparam int TX1_HIGH_LSB  = 15;
   localparam int TX2_LOW_LSB   = 20;
   localparam int TX2_LOW_W     = 4;
   // Field positions in the control register
   localparam int SW_EN_BIT     = 0;
   localparam int FIX_CH_LSB    = 1;
   localparam int SEQ_LSB       = 3;
   localparam int SEQ_W         = 12;
   localparam int ADAPT_EN_BIT  = 15;
   localparam int FIX_LVL_BIT   = 16;
   localparam int TX2_HIGH_LSB  = 18;
   localparam int TX2_LOW_MSB_BIT = 23;

   localparam int CODE_W        = 5;
   localparam int THR_W         = 16;
   localparam int SUBCNT_W      = 12;
   localparam int SEQ_ENTRIES   = 6;

   // Sub-frame length: 10,000 sequencer clocks at 40 MHz
   localparam int SUBFRAME_SEQ_CLKS = 10000;
   localparam int SEQ_CLK_NS        = 25;
   localparam int SUBFRAME_NS       = SUBFRAME_SEQ_CLKS * SEQ_CLK_NS;
   localparam int SYS_CLK_MHZ       = 200;
   localparam int SUBFRAME_CYC      = SUBFRAME_NS * SYS_CLK_MHZ / 1000;

   typedef enum logic [0:0] {
      ST_IDLE,
      ST_RUN
   } hts_state_e;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [23:0] wdata;
   } hts_reg_req_s;

   typedef struct packed {
      logic [CODE_W-1:0] low;
      logic [CODE_W-1:0] high;
   } hts_codes_s;

endpackage : hts_pkg

// >>> hts_sequencer.sv
// Illumination level and emitter channel sequencer with its configuration registers.
// Assumes register requests, run control and amplitude results come from logic on CLK_SYS_I.
// Summary of operation
// - Adaptive, high level: above saturation go low
// - Adaptive, low level: below accuracy go high
// - Judge level from first sub-frame result
// - Keep or swap level for rest of frame
// - Adaptive off: one-bit select fixes level
// - Each channel has low and high codes
// - Third channel low code spans two registers
// - At most one emitter output active
// - Switching enabled: change channel between samples
// - Six two-bit entries, lowest first, repeating
// - Switching disabled: use fixed channel select
// - Calibration set follows active channel
// - Sequencing works in every run mode
// - Sub-frame 10,000 sequencer clocks, count plus one
`timescale 1ns/1ps
module hts_sequencer #(
   parameter int SUBFRAME_CYC = hts_pkg::SUBFRAME_CYC
) (
   input  wire logic                         CLK_SYS_I,
   input  wire logic                         RSTN_I,
   input  wire logic                         CE_I,
   input  wire hts_pkg::hts_reg_req_s        REG_REQ_I,
   output logic [23:0]                       REG_RDATA_O,
   output logic                              REG_RVALID_O,
   input  wire logic                         RUN_I,
   input  wire logic [hts_pkg::SUBCNT_W-1:0] NUM_SUB_FRAMES_I,
   input  wire logic                         AMP_VALID_I,
   input  wire logic [hts_pkg::THR_W-1:0]    AMP_I,
   output logic [2:0]                        TX_EN_O,
   output logic [hts_pkg::CODE_W-1:0]        CURRENT_CODE_O,
   output logic                              LEVEL_HIGH_O,
   output logic [2:0]                        CAL_SEL_O,
   output logic                              FRAME_START_O,
   output logic                              SUBFRAME_START_O
);

   localparam int CYC_W = $clog2(SUBFRAME_CYC);
   localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(SUBFRAME_CYC - 1);

   // Configuration registers
   logic [23:0]                     codes_q, codes_d;
   logic [23:0]                     ctrl_q, ctrl_d;
   logic [hts_pkg::THR_W-1:0]       sat_q, sat_d;
   logic [hts_pkg::THR_W-1:0]       acc_q, acc_d;
   logic [23:0]                     rdata_q, rdata_d;
   logic                            rvalid_q, rvalid_d;

   // Sequencing state
   hts_pkg::hts_state_e             state_q, state_d;
   logic [CYC_W-1:0]                cyc_q, cyc_d;
   logic [hts_pkg::SUBCNT_W-1:0]    sub_q, sub_d;
   logic [2:0]                      seq_idx_q, seq_idx_d;
   logic [1:0]                      ch_q, ch_d;
   logic                            lvl_q, lvl_d;
   logic [2:0]                      tx_en_q, tx_en_d;
   logic [hts_pkg::CODE_W-1:0]      code_q, code_d;
   logic                            out_lvl_q, out_lvl_d;
   logic [2:0]                      cal_q, cal_d;
   logic                            fstart_q, fstart_d;
   logic                            sstart_q, sstart_d;

   logic                            sw_en;
   logic                            adapt_en;
   logic                            eff_lvl;
   logic                            frame_begin;
   hts_pkg::hts_codes_s             ch_codes [3];

   // Per-channel code sets
   always_comb
   begin
      ch_codes[0].low  = codes_q[hts_pkg::TX0_LOW_LSB  +: hts_pkg::CODE_W];
      ch_codes[0].high = codes_q[hts_pkg::TX0_HIGH_LSB +: hts_pkg::CODE_W];
      ch_codes[1].low  = codes_q[hts_pkg::TX1_LOW_LSB  +: hts_pkg::CODE_W];
      ch_codes[1].high = codes_q[hts_pkg::TX1_HIGH_LSB +: hts_pkg::CODE_W];
      ch_codes[2].low  = {ctrl_q[hts_pkg::TX2_LOW_MSB_BIT],
                          codes_q[hts_pkg::TX2_LOW_LSB +: hts_pkg::TX2_LOW_W]};
      ch_codes[2].high = ctrl_q[hts_pkg::TX2_HIGH_LSB +: hts_pkg::CODE_W];
   end

   // Register writes
   always_comb
   begin
      codes_d  = codes_q;
      ctrl_d   = ctrl_q;
      sat_d    = sat_q;
      acc_d    = acc_q;
      if (REG_REQ_I.wr)
      begin
         if (REG_REQ_I.addr == hts_pkg::ADDR_TX_CODES)
            codes_d = REG_REQ_I.wdata;
         else if (REG_REQ_I.addr == hts_pkg::ADDR_TX_CTRL)
            ctrl_d = REG_REQ_I.wdata;
         else if (REG_REQ_I.addr == hts_pkg::ADDR_SAT_THR)
            sat_d = REG_REQ_I.wdata[hts_pkg::THR_W-1:0];
         else if (REG_REQ_I.addr == hts_pkg::ADDR_ACC_THR)
            acc_d = REG_REQ_I.wdata[hts_pkg::THR_W-1:0];
      end
   end

   // Writes land at the edge that takes them
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
      begin
         codes_q <= hts_pkg::TX_CODES_RST;
         ctrl_q  <= hts_pkg::TX_CTRL_RST;
         sat_q   <= hts_pkg::SAT_THR_RST;
         acc_q   <= hts_pkg::ACC_THR_RST;
      end
      else if (CE_I)
      begin
         codes_q <= codes_d;
         ctrl_q  <= ctrl_d;
         sat_q   <= sat_d;
         acc_q   <= acc_d;
      end
   end

   // Read data stands until the next read
   always_comb
   begin
      rdata_d  = rdata_q;
      rvalid_d = REG_REQ_I.rd;
      if (REG_REQ_I.rd)
      begin
         if (REG_REQ_I.addr == hts_pkg::ADDR_TX_CODES)
            rdata_d = codes_q;
         else if (REG_REQ_I.addr == hts_pkg::ADDR_TX_CTRL)
            rdata_d = ctrl_q;
         else if (REG_REQ_I.addr == hts_pkg::ADDR_SAT_THR)
            rdata_d = {8'h00, sat_q};
         else if (REG_REQ_I.addr == hts_pkg::ADDR_ACC_THR)
            rdata_d = {8'h00, acc_q};
         else
            rdata_d = 24'h000000;
      end
   end

   always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
      begin
         rdata_q  <= 24'h000000;
         rvalid_q <= 1'b0;
      end
      else if (CE_I)
      begin
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   assign sw_en    = ctrl_q[hts_pkg::SW_EN_BIT];
   assign adapt_en = ctrl_q[hts_pkg::ADAPT_EN_BIT];

   // Frame timing, channel stepping and level decision
   always_comb
   begin
      state_d     = state_q;
      cyc_d       = cyc_q;
      sub_d       = sub_q;
      seq_idx_d   = seq_idx_q;
      ch_d        = ch_q;
      lvl_d       = lvl_q;
      frame_begin = 1'b0;
      sstart_d    = 1'b0;
      case (state_q)
         hts_pkg::ST_IDLE:
         begin
            if (RUN_I)
            begin
               state_d     = hts_pkg::ST_RUN;
               frame_begin = 1'b1;
            end
         end
         hts_pkg::ST_RUN:
         begin
            if (cyc_q == CYC_LAST)
            begin
               cyc_d = '0;
               if (sub_q >= NUM_SUB_FRAMES_I)
               begin
                  sub_d = '0;
                  if (RUN_I)
                     frame_begin = 1'b1;
                  else
                     state_d = hts_pkg::ST_IDLE;
               end
               else
               begin
                  sub_d    = sub_q + 1'b1;
                  sstart_d = 1'b1;
               end
            end
            else
               cyc_d = cyc_q + 1'b1;
            // First sub-frame result steers the rest of the frame
            if (adapt_en && AMP_VALID_I && sub_q == '0)
            begin
               if (lvl_q && AMP_I > sat_q)
                  lvl_d = 1'b0;
               else if (!lvl_q && AMP_I < acc_q)
                  lvl_d = 1'b1;
            end
         end
         default:
            state_d = hts_pkg::ST_IDLE;
      endcase
      if (frame_begin)
      begin
         cyc_d    = '0;
         sub_d    = '0;
         sstart_d = 1'b1;
         if (sw_en)
         begin
            ch_d      = ctrl_q[hts_pkg::SEQ_LSB + 2*seq_idx_q +: 2];
            seq_idx_d = (seq_idx_q == 3'(hts_pkg::SEQ_ENTRIES - 1)) ? 3'h0 : seq_idx_q + 3'h1;
         end
         else
         begin
            ch_d      = ctrl_q[hts_pkg::FIX_CH_LSB +: 2];
            seq_idx_d = 3'h0;
         end
      end
      fstart_d = frame_begin;
   end

   // Emitter drive stage follows the next channel and level
   always_comb
   begin
      // Decided level is kept across frames
      eff_lvl  = adapt_en ? lvl_d : ctrl_q[hts_pkg::FIX_LVL_BIT];
      tx_en_d  = 3'h0;
      code_d   = '0;
      if (state_d == hts_pkg::ST_RUN && ch_d != 2'h3)
      begin
         tx_en_d = 3'(1) << ch_d;
         code_d  = eff_lvl ? ch_codes[ch_d].high : ch_codes[ch_d].low;
      end
      out_lvl_d = eff_lvl;
      cal_d     = {ch_d, eff_lvl};
   end

   always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
      begin
         state_q   <= hts_pkg::ST_IDLE;
         cyc_q     <= '0;
         sub_q     <= '0;
         seq_idx_q <= 3'h0;
         ch_q      <= 2'h0;
         lvl_q     <= 1'b0;
         fstart_q  <= 1'b0;
         sstart_q  <= 1'b0;
      end
      else if (CE_I)
      begin
         state_q   <= state_d;
         cyc_q     <= cyc_d;
         sub_q     <= sub_d;
         seq_idx_q <= seq_idx_d;
         ch_q      <= ch_d;
         lvl_q     <= lvl_d;
         fstart_q  <= fstart_d;
         sstart_q  <= sstart_d;
      end
   end

   // Emitter drive registers
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
      begin
         tx_en_q   <= 3'h0;
         code_q    <= '0;
         out_lvl_q <= 1'b0;
         cal_q     <= 3'h0;
      end
      else if (CE_I)
      begin
         tx_en_q   <= tx_en_d;
         code_q    <= code_d;
         out_lvl_q <= out_lvl_d;
         cal_q     <= cal_d;
      end
   end

   assign REG_RDATA_O      = rdata_q;
   assign REG_RVALID_O     = rvalid_q;
   assign TX_EN_O          = tx_en_q;
   assign CURRENT_CODE_O   = code_q;
   assign LEVEL_HIGH_O     = out_lvl_q;
   assign CAL_SEL_O        = cal_q;
   assign FRAME_START_O    = fstart_q;
   assign SUBFRAME_START_O = sstart_q;

endmodule : hts_sequencer

// >>> hts_sequencer_sva.sv
// Port checker for the illumination sequencer.
// Assumes it is bound to every sequencer instance and CE_I is held high.
`timescale 1ns/1ps
module hts_sequencer_sva #(
   parameter int SUBFRAME_CYC = hts_pkg::SUBFRAME_CYC
) (
   input wire logic                  CLK_SYS_I,
   input wire logic                  RSTN_I,
   input wire logic                  CE_I,
   input wire hts_pkg::hts_reg_req_s REG_REQ_I,
   input wire logic                  AMP_VALID_I,
   input wire logic [15:0]           AMP_I,
   input wire logic [2:0]            TX_EN_O,
   input wire logic [4:0]            CURRENT_CODE_O,
   input wire logic                  LEVEL_HIGH_O,
   input wire logic [2:0]            CAL_SEL_O,
   input wire logic                  FRAME_START_O,
   input wire logic                  SUBFRAME_START_O
);
   logic [23:0] c29_q, c2a_q;
   logic [15:0] sat_q, acc_q, gap_q;
   logic        sub0_q, sub0;
   logic [4:0]  exp_code;
   // High while the first sub-frame of a frame runs
   assign sub0 = FRAME_START_O | (sub0_q & ~SUBFRAME_START_O);
   always_comb
   begin
      case (CAL_SEL_O[2:1])
         2'h0:    exp_code = LEVEL_HIGH_O ? c29_q[9:5] : c29_q[4:0];
         2'h1:    exp_code = LEVEL_HIGH_O ? c29_q[19:15] : c29_q[14:10];
         default: exp_code = LEVEL_HIGH_O ? c2a_q[22:18] : {c2a_q[23], c29_q[23:20]};
      endcase
   end
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
      begin
         {c29_q, c2a_q, sat_q, acc_q, gap_q, sub0_q} <= '0;
      end
      else if (CE_I)
      begin
         sub0_q <= sub0;
         gap_q  <= SUBFRAME_START_O ? 16'h0001 : gap_q + 16'h0001;
         if (REG_REQ_I.wr)
         begin
            case (REG_REQ_I.addr)
               hts_pkg::ADDR_TX_CODES: c29_q <= REG_REQ_I.wdata;
               hts_pkg::ADDR_TX_CTRL:  c2a_q <= REG_REQ_I.wdata;
               hts_pkg::ADDR_SAT_THR:  sat_q <= REG_REQ_I.wdata[15:0];
               hts_pkg::ADDR_ACC_THR:  acc_q <= REG_REQ_I.wdata[15:0];
               default: ;
            endcase
         end
      end
   end
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RSTN_I);
   one_emitter_a:
   assert property ($onehot0(TX_EN_O)) else $error("more than one emitter on");
   sub_period_a:
   assert property (SUBFRAME_START_O && !FRAME_START_O |-> gap_q == SUBFRAME_CYC) else $error("sub-frame length");
   sat_down_a:
   assert property (sub0 && AMP_VALID_I && c2a_q[15] && LEVEL_HIGH_O && AMP_I > sat_q |=> !LEVEL_HIGH_O)
      else $error("no switch to low");
   acc_up_a:
   assert property (sub0 && AMP_VALID_I && c2a_q[15] && !LEVEL_HIGH_O && AMP_I < acc_q |=> LEVEL_HIGH_O)
      else $error("no switch to high");
   keep_level_a:
   assert property ((!sub0 && c2a_q[15]) ##1 (c2a_q[15] && TX_EN_O != 3'h0 && !FRAME_START_O)
      |-> $stable(LEVEL_HIGH_O)) else $error("level changed after first sub-frame");
   fixed_level_a:
   assert property (TX_EN_O != 3'h0 && !c2a_q[15] && $stable(c2a_q) |-> LEVEL_HIGH_O == c2a_q[16])
      else $error("fixed level wrong");
   code_map_a:
   assert property (TX_EN_O != 3'h0 && $stable(c29_q) && $stable(c2a_q) |-> CURRENT_CODE_O == exp_code
      && TX_EN_O[CAL_SEL_O[2:1]] && CAL_SEL_O[0] == LEVEL_HIGH_O) else $error("code or set wrong");
   fixed_chan_a:
   assert property (FRAME_START_O && !c2a_q[0] && $stable(c2a_q) |-> TX_EN_O == 3'(3'h1 << c2a_q[2:1]))
      else $error("fixed channel wrong");
endmodule : hts_sequencer_sva
bind hts_sequencer hts_sequencer_sva #(.SUBFRAME_CYC(SUBFRAME_CYC)) hts_sequencer_sva_i (.CLK_SYS_I, .RSTN_I,
   .CE_I, .REG_REQ_I, .AMP_VALID_I, .AMP_I, .TX_EN_O, .CURRENT_CODE_O, .LEVEL_HIGH_O, .CAL_SEL_O,
   .FRAME_START_O, .SUBFRAME_START_O);

// >>> tb_hts_sequencer.sv
// Self-checking bench for the illumination sequencer.
// Assumes the emitter model answers each sub-frame and the checker is bound.
`timescale 1ns/1ps
module tb_hts_sequencer;
   localparam int SUB = 20;
   logic                  clk_sys, rstn, ce, run, amp_valid, rvalid, lvl, frame_start, sub_start;
   hts_pkg::hts_reg_req_s req;
   logic [23:0]           rdata;
   logic [11:0]           num_sub;
   logic [15:0]           amp;
   logic [2:0]            tx_en, cal_sel;
   logic [4:0]            code;
   logic [10:0]           gain;
   logic [2:0]            seq_tx [6] = '{3'h4, 3'h2, 3'h1, 3'h0, 3'h2, 3'h4};
   logic [4:0]            seq_code [6] = '{5'h1E, 5'h0A, 5'h10, 5'h00, 5'h0A, 5'h1E};
   logic [4:0]            fix_code [3] = '{5'h04, 5'h07, 5'h19};
   int                    num_errors = 0;
   int                    comparisons = 0;
   hts_sequencer #(.SUBFRAME_CYC(SUB)) hts_sequencer_i (.CLK_SYS_I(clk_sys), .RSTN_I(rstn), .CE_I(ce),
      .REG_REQ_I(req), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .RUN_I(run), .NUM_SUB_FRAMES_I(num_sub),
      .AMP_VALID_I(amp_valid), .AMP_I(amp), .TX_EN_O(tx_en), .CURRENT_CODE_O(code), .LEVEL_HIGH_O(lvl),
      .CAL_SEL_O(cal_sel), .FRAME_START_O(frame_start), .SUBFRAME_START_O(sub_start));
   hts_emitter_model hts_emitter_model_i (.clk_i(clk_sys), .rstn_i(rstn), .sub_start_i(sub_start),
      .tx_en_i(tx_en), .code_i(code), .gain_i(gain), .amp_valid_o(amp_valid), .amp_o(amp));
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic reg_wr(input logic [7:0] a, input logic [23:0] d);
      @(negedge clk_sys);
      req = '{1'b1, 1'b0, a, d};
      @(negedge clk_sys);
      req = '0;
   endtask : reg_wr
   task automatic reg_rd(input logic [7:0] a, input logic [23:0] exp);
      @(negedge clk_sys);
      req = '{1'b0, 1'b1, a, 24'h0};
      @(negedge clk_sys);
      req = '0;
      check(24'(rvalid), 24'h1);
      check(rdata, exp);
   endtask : reg_rd
   task automatic next_frame(input logic [2:0] exp_tx, input logic exp_lvl, input logic [4:0] exp_code);
      int n = 0;
      do
      begin
         @(negedge clk_sys);
         n++;
      end
      while (frame_start !== 1'b1 && n < 200);
      check(24'(frame_start), 24'h1);
      check(24'(tx_en), 24'(exp_tx));
      check(24'(code), 24'(exp_code));
      if (exp_tx != 3'h0) check(24'(lvl), 24'(exp_lvl));
      if (exp_tx != 3'h0) check(24'(cal_sel), 24'({exp_tx[2], exp_tx[1], exp_lvl}));
   endtask : next_frame
   task automatic idle_wait;
      int n = 0;
      run = 1'b0;
      do
      begin
         @(negedge clk_sys);
         n++;
      end
      while (tx_en !== 3'h0 && n < 200);
      check(24'(n >= 2 * SUB && n <= 2 * SUB + 1), 24'h1);
      check(24'(code), 24'h0);
   endtask : idle_wait
   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : print_verdict
   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   initial
   begin
      #50000;
      num_errors++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      print_verdict();
   end
   initial
   begin
      {rstn, run, req} = '0;
      ce = 1'b1;
      num_sub = 12'h001;
      gain = 11'h3E8;
      repeat (5) @(negedge clk_sys);
      rstn = 1'b1;
      check(24'({tx_en, code, lvl, cal_sel, frame_start, sub_start}), 24'h0);
      reg_rd(hts_pkg::ADDR_TX_CTRL, 24'h0);
      reg_rd(8'h30, 24'h0);
      reg_wr(hts_pkg::ADDR_TX_CODES, {4'h9, 5'h0A, 5'h07, 5'h10, 5'h04});
      reg_wr(hts_pkg::ADDR_SAT_THR, 24'hFF6978);
      reg_rd(hts_pkg::ADDR_SAT_THR, 24'h006978);
      reg_wr(hts_pkg::ADDR_ACC_THR, 24'h0015F9);
      $display("registers done");
      reg_wr(hts_pkg::ADDR_TX_CTRL, 24'hF94E31);
      run = 1'b1;
      for (int i = 0; i < 7; i++) next_frame(seq_tx[i % 6], 1'b1, seq_code[i % 6]);
      idle_wait();
      $display("sequence done");
      for (int ch = 0; ch < 3; ch++)
      begin
         reg_wr(hts_pkg::ADDR_TX_CTRL, 24'hF80000 | 24'(ch << 1));
         run = 1'b1;
         next_frame(3'(1 << ch), 1'b0, fix_code[ch]);
         idle_wait();
      end
      $display("fixed channel done");
      reg_wr(hts_pkg::ADDR_TX_CTRL, 24'hF88000);
      run = 1'b1;
      next_frame(3'h1, 1'b0, 5'h04);
      next_frame(3'h1, 1'b1, 5'h10);
      gain = 11'h7D0;
      next_frame(3'h1, 1'b0, 5'h04);
      next_frame(3'h1, 1'b0, 5'h04);
      idle_wait();
      $display("adaptive done");
      print_verdict();
   end
endmodule : tb_hts_sequencer
